/* File: core/flash_pin_pkg.sv */
// Types and constants for the serial flash pin front end
// Contract
// - Low chip select selects the device; high deselects it and normally enters standby.
// - Operations start on chip select falling and end on chip select rising.
// - Self-timed program or erase keeps running; standby waits until it finishes.
// - Inputs sampled on rising serial clock; outputs change on falling serial clock.
// - Single-bit transfers take every input bit from the serial input line only.
// - Dual and quad output reads turn serial input into driven data line zero.
// - Serial input activity is ignored while chip select is high.
// - Serial output is high impedance whenever the device is deselected.
// - With quad enable set, protect and hold pins become data lines two, three.
package flash_pin_pkg;
    localparam int BYTE_BITS = 8;
    localparam logic RST_CS_N = 1'b1;
    localparam logic RST_SCK = 1'b0;
    localparam logic [2:0] BIT_IDX_LAST = 3'h7;
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hF;

    typedef enum logic [2:0] {
        TX_SINGLE = 3'b001,
        TX_DUAL = 3'b010,
        TX_QUAD = 3'b100
    } tx_mode_t;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_SELECT = 3'b010,
        ST_BUSY = 3'b100
    } link_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic [3:0] io;
    } pins_t;
endpackage

/* File: core/flash_pin_front.sv */
// Serial flash pin front end: selection, standby deferral, shift in and out
`timescale 1ns/1ps
module flash_pin_front
    import flash_pin_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_CS_N,
    input wire logic I_SCK,
    input wire logic [3:0] I_IO,
    input wire logic I_QUAD_IO_ENABLE,
    input wire logic I_BUSY,
    input wire logic I_TX_EN,
    input wire tx_mode_t I_TX_MODE,
    input wire logic [7:0] I_TX_DATA,
    output logic [3:0] O_IO,
    output logic [3:0] O_IO_OE,
    output logic O_SELECTED,
    output logic O_STANDBY,
    output logic O_FRAME_START,
    output logic O_FRAME_END,
    output logic [7:0] O_RX_BYTE,
    output logic O_RX_VALID,
    output logic O_RX_FIRST,
    output logic O_TX_TAKE
);
    function automatic logic [3:0] chunk(input tx_mode_t m, input logic [7:0] d);
        unique case (m)
            TX_SINGLE: chunk = {2'h0, d[7], 1'b0};
            TX_DUAL: chunk = {2'h0, d[7:6]};
            TX_QUAD: chunk = d[7:4];
            default: chunk = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] advance(input tx_mode_t m, input logic [7:0] d);
        unique case (m)
            TX_SINGLE: advance = {d[6:0], 1'b0};
            TX_DUAL: advance = {d[5:0], 2'h0};
            TX_QUAD: advance = {d[3:0], 4'h0};
            default: advance = 8'h00;
        endcase
    endfunction

    function automatic logic [2:0] last_idx(input tx_mode_t m);
        unique case (m)
            TX_SINGLE: last_idx = 3'h7;
            TX_DUAL: last_idx = 3'h3;
            TX_QUAD: last_idx = 3'h1;
            default: last_idx = 3'h0;
        endcase
    endfunction

    // Pin synchroniser, three stages
    pins_t s1_q, s2_q, s3_q;
    logic cs_f_q, cs_f_d, sck_f_q, sck_f_d;
    logic sck_rise, sck_fall, cs_fall, cs_rise, selected;

    always_comb begin
        cs_f_d = (s2_q.cs_n == s3_q.cs_n) ? s3_q.cs_n : cs_f_q;
        sck_f_d = (s2_q.sck == s3_q.sck) ? s3_q.sck : sck_f_q;
        sck_rise = sck_f_d & ~sck_f_q;
        sck_fall = ~sck_f_d & sck_f_q;
        cs_fall = cs_f_q & ~cs_f_d;
        cs_rise = ~cs_f_q & cs_f_d;
        selected = ~cs_f_q;
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            s1_q <= '{cs_n: RST_CS_N, sck: RST_SCK, io: 4'h0};
            s2_q <= '{cs_n: RST_CS_N, sck: RST_SCK, io: 4'h0};
            s3_q <= '{cs_n: RST_CS_N, sck: RST_SCK, io: 4'h0};
            cs_f_q <= RST_CS_N;
            sck_f_q <= RST_SCK;
        end else begin
            s1_q <= '{cs_n: I_CS_N, sck: I_SCK, io: I_IO};
            s2_q <= s1_q;
            s3_q <= s2_q;
            cs_f_q <= cs_f_d;
            sck_f_q <= sck_f_d;
        end
    end

    // Selection and standby state
    link_state_t st_q, st_d;
    logic start_d, end_d, start_q, end_q;

    always_comb begin
        st_d = st_q;
        start_d = cs_fall;
        end_d = cs_rise;
        unique case (st_q)
            ST_STANDBY: if (cs_fall) st_d = ST_SELECT;
            ST_SELECT: if (cs_rise) st_d = I_BUSY ? ST_BUSY : ST_STANDBY;
            ST_BUSY: begin
                if (cs_fall) st_d = ST_SELECT;
                else if (!I_BUSY) st_d = ST_STANDBY;
            end
            default: st_d = ST_STANDBY;
        endcase
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            st_q <= ST_STANDBY;
            start_q <= 1'b0;
            end_q <= 1'b0;
        end else begin
            st_q <= st_d;
            start_q <= start_d;
            end_q <= end_d;
        end
    end

    // Transmit shifter, changes on falling clock
    logic tx_act_q, tx_act_d, take_q, take_d;
    tx_mode_t mode_q, mode_d, mode_in;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic [2:0] tx_cnt_q, tx_cnt_d;
    logic [3:0] out_q, out_d;
    logic wide_out;

    always_comb begin
        mode_in = (I_TX_MODE == TX_QUAD && !I_QUAD_IO_ENABLE) ? TX_SINGLE : I_TX_MODE;
        tx_act_d = tx_act_q;
        take_d = 1'b0;
        mode_d = mode_q;
        tx_sh_d = tx_sh_q;
        tx_cnt_d = tx_cnt_q;
        out_d = out_q;
        if (!selected || cs_rise || cs_fall) begin
            tx_act_d = 1'b0;
            tx_cnt_d = 3'h0;
        end else if (sck_fall && I_TX_EN) begin
            if (!tx_act_q || tx_cnt_q == 3'h0) begin
                mode_d = mode_in;
                out_d = chunk(mode_in, I_TX_DATA);
                tx_sh_d = advance(mode_in, I_TX_DATA);
                tx_cnt_d = last_idx(mode_in);
                tx_act_d = 1'b1;
                take_d = 1'b1;
            end else begin
                out_d = chunk(mode_q, tx_sh_q);
                tx_sh_d = advance(mode_q, tx_sh_q);
                tx_cnt_d = tx_cnt_q - 3'h1;
            end
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            tx_act_q <= 1'b0;
            take_q <= 1'b0;
            mode_q <= TX_SINGLE;
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 3'h0;
            out_q <= 4'h0;
        end else begin
            tx_act_q <= tx_act_d;
            take_q <= take_d;
            mode_q <= mode_d;
            tx_sh_q <= tx_sh_d;
            tx_cnt_q <= tx_cnt_d;
            out_q <= out_d;
        end
    end

    assign wide_out = tx_act_q && mode_q != TX_SINGLE;

    // Receive shifter, samples on rising clock
    logic [7:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
    logic [2:0] rx_cnt_q, rx_cnt_d;
    logic rx_valid_q, rx_valid_d, rx_first_q, rx_first_d, rx_seen_q, rx_seen_d;

    always_comb begin
        rx_sh_d = rx_sh_q;
        rx_cnt_d = rx_cnt_q;
        rx_byte_d = rx_byte_q;
        rx_valid_d = 1'b0;
        rx_first_d = rx_first_q;
        rx_seen_d = rx_seen_q;
        if (!selected || cs_fall) begin
            rx_cnt_d = 3'h0;
            rx_seen_d = 1'b0;
        end else if (sck_rise && !wide_out) begin
            rx_sh_d = {rx_sh_q[6:0], s3_q.io[0]};
            rx_cnt_d = rx_cnt_q + 3'h1;
            if (rx_cnt_q == BIT_IDX_LAST) begin
                rx_byte_d = {rx_sh_q[6:0], s3_q.io[0]};
                rx_valid_d = 1'b1;
                rx_first_d = !rx_seen_q;
                rx_seen_d = 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            rx_sh_q <= 8'h00;
            rx_cnt_q <= 3'h0;
            rx_byte_q <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_first_q <= 1'b0;
            rx_seen_q <= 1'b0;
        end else begin
            rx_sh_q <= rx_sh_d;
            rx_cnt_q <= rx_cnt_d;
            rx_byte_q <= rx_byte_d;
            rx_valid_q <= rx_valid_d;
            rx_first_q <= rx_first_d;
            rx_seen_q <= rx_seen_d;
        end
    end

    always_comb begin
        O_IO_OE = 4'h0;
        if (selected && tx_act_q) begin
            unique case (mode_q)
                TX_SINGLE: O_IO_OE = OE_SINGLE;
                TX_DUAL: O_IO_OE = OE_DUAL;
                TX_QUAD: O_IO_OE = OE_QUAD;
                default: O_IO_OE = 4'h0;
            endcase
        end
    end

    assign O_IO = out_q;
    assign O_SELECTED = selected;
    assign O_STANDBY = st_q == ST_STANDBY;
    assign O_FRAME_START = start_q;
    assign O_FRAME_END = end_q;
    assign O_RX_BYTE = rx_byte_q;
    assign O_RX_VALID = rx_valid_q;
    assign O_RX_FIRST = rx_first_q;
    assign O_TX_TAKE = take_q;

    // Checks
    deselect_standby_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (cs_rise && !I_BUSY) |=> O_STANDBY && !O_SELECTED)
        else $error("no standby after idle deselect");
    frame_start_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        O_FRAME_START |-> O_SELECTED && !$past(O_SELECTED, 2))
        else $error("frame start without chip select fall");
    busy_defer_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (st_q == ST_BUSY && I_BUSY && !cs_fall) |=> !O_STANDBY)
        else $error("standby entered while busy");
    rx_rise_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        O_RX_VALID |-> $past(sck_rise))
        else $error("byte completed off a rising edge");
    tx_fall_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (out_q != $past(out_q)) |-> $past(sck_fall))
        else $error("output changed off a falling edge");
    rx_lsb_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        O_RX_VALID |-> O_RX_BYTE[0] == $past(s3_q.io[0]))
        else $error("last bit not from serial input");
    ignore_in_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        O_RX_VALID |-> $past(O_SELECTED))
        else $error("input taken while deselected");
    deselect_hiz_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !O_SELECTED |-> O_IO_OE == 4'h0)
        else $error("pin driven while deselected");
    io0_wide_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        O_IO_OE[0] |-> mode_q != TX_SINGLE && !O_RX_VALID)
        else $error("data line zero driven in single mode");
    quad_gate_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (sck_fall && I_TX_EN && take_d && !I_QUAD_IO_ENABLE) |=> mode_q != TX_QUAD)
        else $error("quad lines used without quad enable");
    byte_in_c: cover property (@(posedge I_CLOCK) disable iff (I_RST) O_RX_VALID && O_RX_FIRST);
    quad_out_c: cover property (@(posedge I_CLOCK) disable iff (I_RST) O_IO_OE == OE_QUAD);
    busy_wait_c: cover property (@(posedge I_CLOCK) disable iff (I_RST) st_q == ST_BUSY ##1 O_STANDBY);
endmodule

/* File: tb/spi_host_model.sv */
// Behavioural SPI host for the flash pins
`timescale 1ns/1ps
module spi_host_model
    import flash_pin_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] dev_io,
    input wire logic [3:0] dev_oe,
    output pins_t pins
);
    logic si = 1'b0;
    logic cs_n = RST_CS_N;
    logic sck = RST_SCK;
    always_comb begin
        pins.cs_n = cs_n;
        pins.sck = sck;
        pins.io[0] = dev_oe[0] ? dev_io[0] : si;
        pins.io[1] = dev_oe[1] ? dev_io[1] : ~dev_io[1];
        pins.io[3:2] = (dev_io[3:2] & dev_oe[3:2]) | ~dev_oe[3:2];
    end
    task automatic cs(input logic v);
        repeat (8) @(negedge clk);
        cs_n = v;
        repeat (8) @(negedge clk);
    endtask
    task automatic shift(input logic [7:0] b, input int w, input int rd, output logic [7:0] r);
        r = 8'h00;
        for (int k = 0; k < BYTE_BITS / w + rd; k++) begin
            si = b[7];
            b = b << 1;
            repeat (8) @(negedge clk);
            sck = 1'b1;
            case (w)
                1: r = {r[6:0], pins.io[1]};
                2: r = {r[5:0], pins.io[1:0]};
                default: r = {r[3:0], pins.io};
            endcase
            repeat (8) @(negedge clk);
            sck = 1'b0;
        end
    endtask
endmodule

/* File: tb/flash_pin_front_tb.sv */
// Self-checking bench for the flash pin front end
`timescale 1ns/1ps
module flash_pin_front_tb;
    import flash_pin_pkg::*;
    logic I_CLOCK = 1'b0;
    logic I_RST = 1'b1;
    logic I_QUAD_IO_ENABLE = 1'b0;
    logic I_BUSY = 1'b0;
    logic I_TX_EN = 1'b0;
    tx_mode_t I_TX_MODE = TX_SINGLE;
    logic [7:0] I_TX_DATA = 8'h00;
    logic [3:0] O_IO, O_IO_OE;
    logic O_SELECTED, O_STANDBY, O_FRAME_START, O_FRAME_END, O_RX_VALID, O_RX_FIRST, O_TX_TAKE;
    logic [7:0] O_RX_BYTE, r;
    pins_t p;
    int n_mismatch = 0, tests_run = 0, cycles = 0, n_start = 0, n_end = 0, n_take = 0;
    logic [7:0] q_rx[$], q_exp[$];
    logic q_first[$];
    always #50 I_CLOCK = ~I_CLOCK;
    flash_pin_front flash_pin_front_inst (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CS_N(p.cs_n),
        .I_SCK(p.sck), .I_IO(p.io), .I_QUAD_IO_ENABLE(I_QUAD_IO_ENABLE), .I_BUSY(I_BUSY),
        .I_TX_EN(I_TX_EN), .I_TX_MODE(I_TX_MODE), .I_TX_DATA(I_TX_DATA), .O_IO(O_IO),
        .O_IO_OE(O_IO_OE), .O_SELECTED(O_SELECTED), .O_STANDBY(O_STANDBY),
        .O_FRAME_START(O_FRAME_START), .O_FRAME_END(O_FRAME_END), .O_RX_BYTE(O_RX_BYTE),
        .O_RX_VALID(O_RX_VALID), .O_RX_FIRST(O_RX_FIRST), .O_TX_TAKE(O_TX_TAKE));
    spi_host_model spi_host_model_inst (.clk(I_CLOCK), .dev_io(O_IO), .dev_oe(O_IO_OE), .pins(p));
    task automatic finish_test();
        $display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    always @(posedge I_CLOCK) begin
        cycles <= cycles + 1;
        if (O_RX_VALID === 1'b1) begin
            q_rx.push_back(O_RX_BYTE);
            q_first.push_back(O_RX_FIRST);
        end
        if (O_FRAME_START === 1'b1) n_start <= n_start + 1;
        if (O_FRAME_END === 1'b1) n_end <= n_end + 1;
        if (O_TX_TAKE === 1'b1) n_take <= n_take + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    end
    task automatic rd(input tx_mode_t m, input logic qe, input int w, input logic [3:0] oe);
        logic [7:0] d;
        int t0;
        d = 8'($urandom);
        t0 = n_take;
        I_TX_MODE = m;
        I_QUAD_IO_ENABLE = qe;
        I_TX_DATA = d;
        I_TX_EN = 1'b1;
        spi_host_model_inst.cs(1'b0);
        spi_host_model_inst.shift(8'h00, w, 1, r);
        chk(O_IO_OE, oe, "enables");
        chk(r, d, "read data");
        spi_host_model_inst.cs(1'b1);
        I_TX_EN = 1'b0;
        chk(8'(n_take - t0), 8'h02, "tx take");
        chk(O_IO_OE, 4'h0, "release");
    endtask
    initial begin
        void'($urandom(74231));
        repeat (5) @(posedge I_CLOCK);
        @(negedge I_CLOCK);
        I_RST = 1'b0;
        chk(O_STANDBY, 1'b1, "reset standby");
        chk(O_IO_OE, 4'h0, "reset enables");
        spi_host_model_inst.shift(8'hA5, 1, 0, r);
        chk(8'(q_rx.size()), 8'h00, "ignored");
        spi_host_model_inst.cs(1'b0);
        chk(O_SELECTED, 1'b1, "select");
        chk(O_STANDBY, 1'b0, "awake");
        chk(8'(n_start), 8'h01, "start");
        repeat (3) begin
            q_exp.push_back(8'($urandom));
            spi_host_model_inst.shift(q_exp[$], 1, 0, r);
        end
        I_BUSY = 1'b1;
        spi_host_model_inst.cs(1'b1);
        chk(O_SELECTED, 1'b0, "deselect");
        chk(O_STANDBY, 1'b0, "busy defers");
        chk(8'(n_end), 8'h01, "end");
        I_BUSY = 1'b0;
        repeat (3) @(negedge I_CLOCK);
        chk(O_STANDBY, 1'b1, "standby");
        chk(8'(q_rx.size()), 8'h03, "count");
        foreach (q_exp[i]) begin
            chk(q_rx[i], q_exp[i], "rx byte");
            chk(q_first[i], i == 0, "first");
        end
        rd(TX_SINGLE, 1'b0, 1, OE_SINGLE);
        rd(TX_DUAL, 1'b0, 2, OE_DUAL);
        rd(TX_QUAD, 1'b1, 4, OE_QUAD);
        rd(TX_QUAD, 1'b0, 1, OE_SINGLE);
        chk(8'(n_start), 8'h05, "starts");
        chk(8'(n_end), 8'h05, "ends");
        finish_test();
    end
endmodule
